// ===== inc/pwo_pkg.sv
package pwo_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned ADDR_W = 12;
  // register index = printed offset; byte address is four times it
  localparam logic [7:0] IDX_OVR_MODE = 8'hBB;
  localparam logic [7:0] IDX_OVR_LEVEL = 8'hBC;
  localparam logic [7:0] IDX_PIN_SRC = 8'hBD;
  localparam logic [7:0] IDX_CH_EN = 8'hBE;
  localparam logic [11:0] ADDR_OVR_MODE = {2'h0, IDX_OVR_MODE, 2'h0};
  localparam logic [11:0] ADDR_OVR_LEVEL = {2'h0, IDX_OVR_LEVEL, 2'h0};
  localparam logic [11:0] ADDR_PIN_SRC = {2'h0, IDX_PIN_SRC, 2'h0};
  localparam logic [11:0] ADDR_CH_EN = {2'h0, IDX_CH_EN, 2'h0};
  localparam logic [7:0] RST_OVR_MODE = 8'h00;
  localparam logic [7:0] RST_OVR_LEVEL = 8'h00;
  localparam logic [7:0] RST_PIN_SRC = 8'h00;
  localparam logic [7:0] RST_CH_EN = 8'h00;
  localparam logic [7:0] EVEN_MASK = 8'h55;
  localparam logic [7:0] ODD_MASK = 8'hAA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/pwo_stage.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// - override mode 0 passes generator output
// - override mode 1 drives override level bit
// - level bit n maps to channel n
// - level one is active, zero inactive
// - pin source one picks port latch, resets zero
// - pin source honoured only with option enabled
// - even enable bits gate even outputs not taken from the port latch
// - odd enable bits gate odd outputs not taken from the port latch
module pwo_stage (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] gen_out,
  input wire logic [7:0] port_latch,
  input wire logic option_odd_pins_on,
  input wire logic option_even_pins_on,
  input wire logic option_ch6_pin_on,
  input wire logic option_ch7_pin_on,
  output logic [7:0] pin_out
);
  typedef struct packed {
    logic [7:0] ovr_mode;
    logic [7:0] ovr_level;
    logic [7:0] pin_src;
    logic [7:0] ch_en;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] pins;
  } pwo_state_t;

  pwo_state_t st;
  pwo_state_t next_st;
  logic [7:0] after_ovr;
  logic [7:0] after_en;
  logic [7:0] opt_on;
  logic [7:0] src_eff;
  logic wr_go;
  logic ar_miss;

  // options for channels 0..5 come from the odd/even group bits, 6 and 7 from their own
  assign opt_on = {option_ch7_pin_on, option_ch6_pin_on,
                   option_odd_pins_on, option_even_pins_on,
                   option_odd_pins_on, option_even_pins_on,
                   option_odd_pins_on, option_even_pins_on};
  assign after_ovr = (st.ovr_mode & st.ovr_level) | (~st.ovr_mode & gen_out);
  assign after_en = after_ovr & ((st.ch_en & pwo_pkg::EVEN_MASK) |
                                 (st.ch_en & pwo_pkg::ODD_MASK));
  assign src_eff = st.pin_src & opt_on;
  assign wr_go = st.aw_held && st.w_held && !st.bvalid;
  assign ar_miss = (s_axi_araddr != pwo_pkg::ADDR_OVR_MODE) &&
                   (s_axi_araddr != pwo_pkg::ADDR_OVR_LEVEL) &&
                   (s_axi_araddr != pwo_pkg::ADDR_PIN_SRC) &&
                   (s_axi_araddr != pwo_pkg::ADDR_CH_EN);

  assign s_axi_awready = !st.aw_held;
  assign s_axi_wready = !st.w_held;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign pin_out = st.pins;

  always_comb begin
    next_st = st;
    // active level is one; the pin stage registers to keep data outputs glitch free
    next_st.pins = (src_eff & port_latch) | (~src_eff & after_en);
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata[7:0];
      next_st.w_strb0 = s_axi_wstrb[0];
    end
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = pwo_pkg::RESP_OKAY;
      if (st.aw_addr == pwo_pkg::ADDR_OVR_MODE) begin
        if (st.w_strb0) next_st.ovr_mode = st.w_data;
      end else if (st.aw_addr == pwo_pkg::ADDR_OVR_LEVEL) begin
        if (st.w_strb0) next_st.ovr_level = st.w_data;
      end else if (st.aw_addr == pwo_pkg::ADDR_PIN_SRC) begin
        if (st.w_strb0) next_st.pin_src = st.w_data;
      end else if (st.aw_addr == pwo_pkg::ADDR_CH_EN) begin
        if (st.w_strb0) next_st.ch_en = st.w_data;
      end else begin
        next_st.bresp = pwo_pkg::RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = pwo_pkg::RESP_OKAY;
      if (s_axi_araddr == pwo_pkg::ADDR_OVR_MODE) begin
        next_st.rdata = {24'h000000, st.ovr_mode};
      end else if (s_axi_araddr == pwo_pkg::ADDR_OVR_LEVEL) begin
        next_st.rdata = {24'h000000, st.ovr_level};
      end else if (s_axi_araddr == pwo_pkg::ADDR_PIN_SRC) begin
        next_st.rdata = {24'h000000, st.pin_src};
      end else if (s_axi_araddr == pwo_pkg::ADDR_CH_EN) begin
        next_st.rdata = {24'h000000, st.ch_en};
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = pwo_pkg::RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.ovr_mode <= pwo_pkg::RST_OVR_MODE;
      st.ovr_level <= pwo_pkg::RST_OVR_LEVEL;
      st.pin_src <= pwo_pkg::RST_PIN_SRC;
      st.ch_en <= pwo_pkg::RST_CH_EN;
    end else begin
      st <= next_st;
    end
  end

  sequence pwo_ovr_set_s(int n);
    st.ovr_mode[n] && st.ch_en[n] && !src_eff[n];
  endsequence

  property pwo_path_p(int n);
    @(posedge aclk) disable iff (!aresetn)
      pwo_ovr_set_s(n) |=> pin_out[n] == $past(st.ovr_level[n]);
  endproperty

  ovr_drive_ch0_a: assert property (pwo_path_p(0))
    else $error("override level not on pin 0");
  ovr_drive_ch7_a: assert property (pwo_path_p(7))
    else $error("override level not on pin 7");
  gen_pass_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st.ovr_mode[3] && st.ch_en[3] && !src_eff[3]) |=> pin_out[3] == $past(gen_out[3]))
    else $error("generator not passed to pin 3");
  even_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st.ch_en[2] && !src_eff[2]) |=> !pin_out[2])
    else $error("disabled even channel not inactive");
  odd_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!st.ch_en[5] && !src_eff[5] && st.ovr_mode[5] && st.ovr_level[5]) |=> !pin_out[5])
    else $error("disabled odd channel not inactive");
  port_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.pin_src[6] && option_ch6_pin_on) |=> pin_out[6] == $past(port_latch[6]))
    else $error("port latch not on pin 6");
  opt_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.pin_src[1] && !option_odd_pins_on) |=> pin_out[1] == $past(after_en[1]))
    else $error("pin source honoured without option");
  level_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (st.ovr_mode[4] && st.ovr_level[4] && st.ch_en[4] && !src_eff[4]) ##1 1'b1
      |-> pin_out[4])
    else $error("override one not active on pin 4");
  reset_src_a: assert property (@(posedge aclk)
      !aresetn |=> st.pin_src == 8'h00 && st.ch_en == 8'h00)
    else $error("pin source or enable not cleared by reset");

  // every channel gets its own copy of the pin path checks, but channel 5's off check covers only an override driving one
  property pwo_gen_p(int n);
    @(posedge aclk) disable iff (!aresetn)
      (!st.ovr_mode[n] && st.ch_en[n] && !src_eff[n]) |=> pin_out[n] == $past(gen_out[n]);
  endproperty
  property pwo_off_p(int n);
    @(posedge aclk) disable iff (!aresetn)
      (!st.ch_en[n] && !src_eff[n]) |=> !pin_out[n];
  endproperty
  property pwo_zero_p(int n);
    @(posedge aclk) disable iff (!aresetn)
      (st.ovr_mode[n] && !st.ovr_level[n] && !src_eff[n]) |=> !pin_out[n];
  endproperty
  // the option pin is passed in so the check does not lean on the option map above
  property pwo_port_p(int n, logic opt);
    @(posedge aclk) disable iff (!aresetn)
      (st.pin_src[n] && opt) |=> pin_out[n] == $past(port_latch[n]);
  endproperty
  // a source bit without its option must leave a disabled channel inactive
  property pwo_gate_p(int n, logic opt);
    @(posedge aclk) disable iff (!aresetn)
      (st.pin_src[n] && !opt && !st.ch_en[n]) |=> !pin_out[n];
  endproperty

  ovr_drive_ch1_a: assert property (pwo_path_p(1))
    else $error("override level not on pin 1");
  ovr_drive_ch2_a: assert property (pwo_path_p(2))
    else $error("override level not on pin 2");
  ovr_drive_ch3_a: assert property (pwo_path_p(3))
    else $error("override level not on pin 3");
  ovr_drive_ch4_a: assert property (pwo_path_p(4))
    else $error("override level not on pin 4");
  ovr_drive_ch5_a: assert property (pwo_path_p(5))
    else $error("override level not on pin 5");
  ovr_drive_ch6_a: assert property (pwo_path_p(6))
    else $error("override level not on pin 6");

  gen_pass_ch0_a: assert property (pwo_gen_p(0))
    else $error("generator not passed to pin 0");
  gen_pass_ch1_a: assert property (pwo_gen_p(1))
    else $error("generator not passed to pin 1");
  gen_pass_ch2_a: assert property (pwo_gen_p(2))
    else $error("generator not passed to pin 2");
  gen_pass_ch4_a: assert property (pwo_gen_p(4))
    else $error("generator not passed to pin 4");
  gen_pass_ch5_a: assert property (pwo_gen_p(5))
    else $error("generator not passed to pin 5");
  gen_pass_ch6_a: assert property (pwo_gen_p(6))
    else $error("generator not passed to pin 6");
  gen_pass_ch7_a: assert property (pwo_gen_p(7))
    else $error("generator not passed to pin 7");

  ch_off_ch0_a: assert property (pwo_off_p(0))
    else $error("disabled channel 0 not inactive");
  ch_off_ch1_a: assert property (pwo_off_p(1))
    else $error("disabled channel 1 not inactive");
  ch_off_ch3_a: assert property (pwo_off_p(3))
    else $error("disabled channel 3 not inactive");
  ch_off_ch4_a: assert property (pwo_off_p(4))
    else $error("disabled channel 4 not inactive");
  ch_off_ch6_a: assert property (pwo_off_p(6))
    else $error("disabled channel 6 not inactive");
  ch_off_ch7_a: assert property (pwo_off_p(7))
    else $error("disabled channel 7 not inactive");

  level_zero_ch0_a: assert property (pwo_zero_p(0))
    else $error("override zero not inactive on pin 0");
  level_zero_ch1_a: assert property (pwo_zero_p(1))
    else $error("override zero not inactive on pin 1");
  level_zero_ch2_a: assert property (pwo_zero_p(2))
    else $error("override zero not inactive on pin 2");
  level_zero_ch3_a: assert property (pwo_zero_p(3))
    else $error("override zero not inactive on pin 3");
  level_zero_ch4_a: assert property (pwo_zero_p(4))
    else $error("override zero not inactive on pin 4");
  level_zero_ch5_a: assert property (pwo_zero_p(5))
    else $error("override zero not inactive on pin 5");
  level_zero_ch6_a: assert property (pwo_zero_p(6))
    else $error("override zero not inactive on pin 6");
  level_zero_ch7_a: assert property (pwo_zero_p(7))
    else $error("override zero not inactive on pin 7");

  port_src_ch0_a: assert property (pwo_port_p(0, option_even_pins_on))
    else $error("port latch not on pin 0");
  port_src_ch1_a: assert property (pwo_port_p(1, option_odd_pins_on))
    else $error("port latch not on pin 1");
  port_src_ch2_a: assert property (pwo_port_p(2, option_even_pins_on))
    else $error("port latch not on pin 2");
  port_src_ch3_a: assert property (pwo_port_p(3, option_odd_pins_on))
    else $error("port latch not on pin 3");
  port_src_ch4_a: assert property (pwo_port_p(4, option_even_pins_on))
    else $error("port latch not on pin 4");
  port_src_ch5_a: assert property (pwo_port_p(5, option_odd_pins_on))
    else $error("port latch not on pin 5");
  port_src_ch7_a: assert property (pwo_port_p(7, option_ch7_pin_on))
    else $error("port latch not on pin 7");

  src_gate_ch0_a: assert property (pwo_gate_p(0, option_even_pins_on))
    else $error("pin source honoured without option on pin 0");
  src_gate_ch2_a: assert property (pwo_gate_p(2, option_even_pins_on))
    else $error("pin source honoured without option on pin 2");
  src_gate_ch3_a: assert property (pwo_gate_p(3, option_odd_pins_on))
    else $error("pin source honoured without option on pin 3");
  src_gate_ch4_a: assert property (pwo_gate_p(4, option_even_pins_on))
    else $error("pin source honoured without option on pin 4");
  src_gate_ch5_a: assert property (pwo_gate_p(5, option_odd_pins_on))
    else $error("pin source honoured without option on pin 5");
  src_gate_ch6_a: assert property (pwo_gate_p(6, option_ch6_pin_on))
    else $error("pin source honoured without option on pin 6");
  src_gate_ch7_a: assert property (pwo_gate_p(7, option_ch7_pin_on))
    else $error("pin source honoured without option on pin 7");

  // bus side: answers stand until taken, and a held channel refuses more
  sequence pwo_wr_both_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence pwo_rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pwo_wr_both_s |-> ##2 s_axi_bvalid)
    else $error("write response not raised two cycles after address and data");
  b_stand_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  b_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response still shown after it was taken");
  rd_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pwo_rd_take_s |=> s_axi_rvalid)
    else $error("read data not shown one cycle after the address");
  r_stand_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && !s_axi_rready)
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data changed before it was taken");
  r_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read data still shown after it was taken");
  aw_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready)
    else $error("second write address accepted while one is held");
  w_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_wvalid && s_axi_wready) |=> !s_axi_wready)
    else $error("second write data accepted while one is held");
  rd_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == pwo_pkg::ADDR_PIN_SRC)
      |=> s_axi_rdata == {24'h000000, $past(st.pin_src)})
    else $error("pin source read back wrong");
  rd_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == pwo_pkg::ADDR_CH_EN)
      |=> s_axi_rdata == {24'h000000, $past(st.ch_en)})
    else $error("channel enable read back wrong");
  rd_miss_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && ar_miss)
      |=> s_axi_rresp == pwo_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  wr_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && st.w_strb0 && st.aw_addr == pwo_pkg::ADDR_PIN_SRC)
      |=> st.pin_src == $past(st.w_data))
    else $error("pin source write lost");
  wr_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && st.w_strb0 && st.aw_addr == pwo_pkg::ADDR_CH_EN)
      |=> st.ch_en == $past(st.w_data))
    else $error("channel enable write lost");
  strb_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && !st.w_strb0) |=> $stable(st.ovr_mode) && $stable(st.ovr_level)
      && $stable(st.pin_src) && $stable(st.ch_en))
    else $error("register changed by a write with its byte lane off");
  reg_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !wr_go |=> $stable(st.ovr_mode) && $stable(st.ovr_level)
      && $stable(st.pin_src) && $stable(st.ch_en))
    else $error("register changed without a write");
endmodule

// ===== testbench/pwo_load.sv
`timescale 1ns/1ps
module pwo_load (
  input wire logic aclk,
  input wire logic [7:0] pin_out,
  output logic [7:0] pin_seen
);
  // a resistive load settles to the driven level by the next edge
  always_ff @(posedge aclk) begin
    pin_seen <= pin_out;
  end
endmodule

// ===== testbench/pwo_stage_test.sv
`timescale 1ns/1ps
module pwo_stage_test;
  logic aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rdat;
  logic awr, wr_r, bv, arr, rv;
  logic [1:0] br, rr;
  logic [7:0] gen = 8'h0, lat = 8'h0, pins, seen, m, l, s, e;
  logic [3:0] opt = 4'h0, ws = 4'hF;
  int n_fail = 0, tests_run = 0, cyc = 0;
  logic [31:0] cfg [6] = '{32'h000000FF, 32'hFFA500FF, 32'h0F3C0055, 32'hF0FF00AA,
                           32'hFFFFFF00, 32'h33C35AF0};
  always #25 aclk = ~aclk;
  pwo_stage u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .gen_out(gen), .port_latch(lat),
    .option_even_pins_on(opt[0]), .option_odd_pins_on(opt[1]), .option_ch6_pin_on(opt[2]),
    .option_ch7_pin_on(opt[3]), .pin_out(pins));
  pwo_load u_load (.aclk(aclk), .pin_out(pins), .pin_seen(seen));
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", n_fail, tests_run);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wr_r) wv <= 1'h0;
    end while (!bv);
    check(br, r);
    bry <= 1'h0;
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    d = rdat;
    r = rr;
    rry <= 1'h0;
  endtask
  // source select only counts where the matching option is on
  function automatic logic [7:0] pexp();
    logic [7:0] o, hon;
    o = ((m & l) | (~m & gen)) & e;
    hon = {opt[3], opt[2], opt[1], opt[0], opt[1], opt[0], opt[1], opt[0]} & s;
    return (hon & lat) | (~hon & o);
  endfunction
  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    check(pins, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd(pwo_pkg::ADDR_OVR_MODE + 12'(4 * i), d, r);
      check(d, 32'h0);
    end
    rd(12'h000, d, r);
    check(r, {30'h0, pwo_pkg::RESP_SLVERR});
    wr(12'h000, 8'hFF, pwo_pkg::RESP_SLVERR);
    // byte lane 0 off: the write is answered but must not land
    ws <= 4'h0;
    wr(pwo_pkg::ADDR_CH_EN, 8'hFF, pwo_pkg::RESP_OKAY);
    ws <= 4'hF;
    rd(pwo_pkg::ADDR_CH_EN, d, r);
    check(d, 32'h0);
  endtask
  task t_path;
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < 6; k++) begin
      for (int i = 0; i < 4; i++) wr(pwo_pkg::ADDR_OVR_MODE + 12'(4 * i), cfg[k][31-8*i-:8],
        pwo_pkg::RESP_OKAY);
      {m, l, s, e} = cfg[k];
      rd(pwo_pkg::ADDR_PIN_SRC, d, r);
      check(d, {24'h0, s});
      check(r, {30'h0, pwo_pkg::RESP_OKAY});
      for (int j = 0; j < 4; j++) begin
        gen <= 8'h5C + 8'(j);
        lat <= 8'h3A ^ 8'(j * 17);
        opt <= 4'(j * 5);
        // the load lags the pin by one edge, so both have settled after three
        repeat (3) @(posedge aclk);
        check(pins, pexp());
        check(seen, pexp());
      end
    end
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_path;
    test_done;
  end
endmodule
